//--- core/prox_pkg.sv
package prox_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned SAMPLE_UNIT_US = 88;
  localparam int unsigned SAMPLE_UNIT_CYC = SAMPLE_UNIT_US * CYC_PER_US;
  // Wait step of 2.78 ms, held in microseconds
  localparam int unsigned WAIT_UNIT_US = 2780;
  localparam int unsigned WAIT_UNIT_CYC = WAIT_UNIT_US * CYC_PER_US;
  localparam int unsigned LONG_WAIT_FACTOR = 12;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PULSE = 8'h04;
  localparam logic [7:0] REG_TIMING = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_MASK = 8'h10;
  localparam logic [7:0] REG_STATE = 8'h14;

  // Field positions
  localparam int CTRL_PON_BIT = 0;
  localparam int CTRL_WAIT_EN_BIT = 1;
  localparam int CTRL_LONG_BIT = 2;
  localparam int CTRL_SAI_BIT = 3;
  localparam int PULSE_CNT_LSB = 0;
  localparam int PULSE_WID_LSB = 8;
  localparam int PULSE_DRV_LSB = 12;
  localparam int TIM_PERIOD_LSB = 0;
  localparam int TIM_WAIT_LSB = 8;
  localparam int TIM_AVG_LSB = 16;
  localparam int TIM_MAVG_LSB = 20;
  localparam int STATE_PULSES_LSB = 8;
  localparam int STATE_AVG_LSB = 16;

  // Writable bits and values after reset
  localparam logic [31:0] CTRL_WMASK = 32'h0000_000F;
  localparam logic [31:0] PULSE_WMASK = 32'h0000_373F;
  localparam logic [31:0] TIMING_WMASK = 32'h0037_FFFF;
  localparam logic [31:0] MASK_WMASK = 32'h0000_0003;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] PULSE_RESET = 32'h0000_0503;
  localparam logic [31:0] TIMING_RESET = 32'h0000_001F;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_SLEEP, ST_ACTIVE, ST_IDLE, ST_HALT} state_t;

  typedef struct packed {
    logic power_on;
    logic wait_en;
    logic long_wait;
    logic sleep_after_interrupt;
    logic [5:0] pulse_count;
    logic [2:0] pulse_width;
    logic [1:0] drive;
    logic [7:0] sample_period;
    logic [7:0] inter_sample_wait;
    logic [2:0] avg_log2;
    logic [1:0] mavg_log2;
  } cfg_t;

  // Pulse high time in clock cycles: 1/2/4/8/12/16/24/32 us
  function automatic logic [9:0] pulse_cycles(input logic [2:0] code);
    logic [5:0] us;
    case (code)
      3'd0: us = 6'd1;
      3'd1: us = 6'd2;
      3'd2: us = 6'd4;
      3'd3: us = 6'd8;
      3'd4: us = 6'd12;
      3'd5: us = 6'd16;
      3'd6: us = 6'd24;
      default: us = 6'd32;
    endcase
    return 10'({4'h0, us} * 10'(CYC_PER_US));
  endfunction : pulse_cycles

endpackage : prox_pkg

//--- core/proximity_cycle_sequencer.sv
`timescale 1ns/1ns

// Contract
// - While powered, the measurement loop repeats, timed from configuration.
// - A sample is a programmable pulse train; emitter on only when pulse high.
// - Pulse count gives one to sixty-four pulses per sample.
// - Pulse width picks high time from one to thirty-two microseconds.
// - Sample period sets minimum sample length, 88 us to 22528 us.
// - Pulsing happens only in active state, never idle or sleep.
// - Optional wait between cycles, 2.78 ms to 712 ms.
// - Long-wait flag multiplies the wait by twelve.
// - Hardware averaging repeats 1 to 128 samples into one result.
// - Moving average delays results only at loop start.
// - Drive strength changes drive level only, never timing.
// - Emitter enable on only in pulse high time and active state; emitter_drive holds the latched level in every state.
// - Wait is (field+1)*2.78 ms before the long extension.
// - Sleep when power bit clear; else active sampling, idle otherwise.
// - Sleep-after-interrupt halts after interrupt until host clears flags.
module proximity_cycle_sequencer #(
  parameter int unsigned WAIT_UNIT_CYC = prox_pkg::WAIT_UNIT_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Emitter and state
  output logic emitter_en,
  output logic [1:0] emitter_drive,
  output logic active,
  output logic sleeping,
  output logic irq
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q, pulse_q, timing_q, mask_q;
  logic aw_hold, w_hold, rd_hit;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, rd_word;
  logic [3:0] w_strb_q;
  logic [1:0] stat;
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb,
                                        input logic [31:0] wmask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return ((old & ~lanes) | (data & lanes)) & wmask;
  endfunction : merge
  wire aw_fire = awvalid && awready;
  wire w_fire = wvalid && wready;
  wire have_aw = aw_hold || aw_fire;
  wire have_w = w_hold || w_fire;
  wire wr_go = have_aw && have_w;
  wire [7:0] wr_addr = aw_hold ? aw_addr_q : awaddr;
  wire [31:0] wr_data = w_hold ? w_data_q : wdata;
  wire [3:0] wr_strb = w_hold ? w_strb_q : wstrb;
  wire wr_ctrl = wr_go && wr_addr == prox_pkg::REG_CTRL;
  wire wr_pulse = wr_go && wr_addr == prox_pkg::REG_PULSE;
  wire wr_timing = wr_go && wr_addr == prox_pkg::REG_TIMING;
  wire wr_mask = wr_go && wr_addr == prox_pkg::REG_MASK;
  wire wr_ok = wr_ctrl || wr_pulse || wr_timing || wr_mask ||
               wr_addr == prox_pkg::REG_STATUS;
  wire ar_fire = arvalid && arready;
  wire rd_clr = ar_fire && araddr == prox_pkg::REG_STATUS;
  assign awready = !aw_hold && !bvalid;
  assign wready = !w_hold && !bvalid;
  assign arready = !rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= prox_pkg::RESP_OKAY;
    end else begin
      aw_hold <= have_aw && !wr_go;
      w_hold <= have_w && !wr_go;
      if (aw_fire) aw_addr_q <= awaddr;
      if (w_fire) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? prox_pkg::RESP_OKAY : prox_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= prox_pkg::CTRL_RESET;
      pulse_q <= prox_pkg::PULSE_RESET;
      timing_q <= prox_pkg::TIMING_RESET;
      mask_q <= prox_pkg::MASK_RESET;
    end else begin
      if (wr_ctrl)
        ctrl_q <= merge(ctrl_q, wr_data, wr_strb, prox_pkg::CTRL_WMASK);
      if (wr_pulse)
        pulse_q <= merge(pulse_q, wr_data, wr_strb, prox_pkg::PULSE_WMASK);
      if (wr_timing)
        timing_q <= merge(timing_q, wr_data, wr_strb, prox_pkg::TIMING_WMASK);
      if (wr_mask)
        mask_q <= merge(mask_q, wr_data, wr_strb, prox_pkg::MASK_WMASK);
    end
  end

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  prox_pkg::cfg_t cfg, lat;
  prox_pkg::state_t st;
  logic [19:0] samp_cnt;
  logic [9:0] ph_cnt;
  logic ph_high;
  logic [6:0] pulses_done;
  logic [7:0] avg_left;
  logic [31:0] wait_cnt;
  logic [2:0] warm_cnt;
  function automatic logic [7:0] pow2_minus1(input logic [2:0] code);
    return 8'((9'h001 << code) - 9'h001);
  endfunction : pow2_minus1
  assign cfg.power_on = ctrl_q[prox_pkg::CTRL_PON_BIT];
  assign cfg.wait_en = ctrl_q[prox_pkg::CTRL_WAIT_EN_BIT];
  assign cfg.long_wait = ctrl_q[prox_pkg::CTRL_LONG_BIT];
  assign cfg.sleep_after_interrupt = ctrl_q[prox_pkg::CTRL_SAI_BIT];
  assign cfg.pulse_count = pulse_q[prox_pkg::PULSE_CNT_LSB +: 6];
  assign cfg.pulse_width = pulse_q[prox_pkg::PULSE_WID_LSB +: 3];
  assign cfg.drive = pulse_q[prox_pkg::PULSE_DRV_LSB +: 2];
  assign cfg.sample_period = timing_q[prox_pkg::TIM_PERIOD_LSB +: 8];
  assign cfg.inter_sample_wait = timing_q[prox_pkg::TIM_WAIT_LSB +: 8];
  assign cfg.avg_log2 = timing_q[prox_pkg::TIM_AVG_LSB +: 3];
  assign cfg.mavg_log2 = timing_q[prox_pkg::TIM_MAVG_LSB +: 2];

  // ----------------------------------------------------------------
  // Cycle timing
  // ----------------------------------------------------------------
  wire [19:0] period_cyc = 20'(({12'h000, lat.sample_period} + 20'h0_0001)
                           * 20'(prox_pkg::SAMPLE_UNIT_CYC));
  wire [31:0] wait_base = 32'(({24'h00_0000, lat.inter_sample_wait}
                          + 32'h0000_0001) * WAIT_UNIT_CYC);
  wire [31:0] wait_target = lat.long_wait ?
                            32'(wait_base * prox_pkg::LONG_WAIT_FACTOR) :
                            wait_base;
  wire [9:0] width_cyc = prox_pkg::pulse_cycles(lat.pulse_width);
  wire [6:0] pulse_total = {1'b0, lat.pulse_count} + 7'd1;
  wire pulses_all = pulses_done == pulse_total;
  // Sample cannot end before the last pulse, which stretches short periods
  wire samp_end = st == prox_pkg::ST_ACTIVE && pulses_all &&
                  samp_cnt >= period_cyc - 20'h0_0001;
  wire cyc_end = samp_end && avg_left == 8'h00;
  wire [7:0] mavg_need = pow2_minus1({1'b0, cfg.mavg_log2});
  wire result_ok = warm_cnt >= mavg_need[2:0];
  wire idle_go = st == prox_pkg::ST_IDLE && !(cfg.sleep_after_interrupt && irq) &&
                 (!lat.wait_en || wait_cnt == wait_target - 32'h0000_0001);
  wire go_sample = cfg.power_on && (st == prox_pkg::ST_SLEEP || idle_go ||
                   (samp_end && avg_left != 8'h00));

  // ----------------------------------------------------------------
  // Loop state
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= prox_pkg::ST_SLEEP;
    end else if (!cfg.power_on) begin
      st <= prox_pkg::ST_SLEEP;
    end else begin
      case (st)
        prox_pkg::ST_SLEEP: st <= prox_pkg::ST_ACTIVE;
        prox_pkg::ST_ACTIVE: if (cyc_end) st <= prox_pkg::ST_IDLE;
        prox_pkg::ST_IDLE: begin
          if (cfg.sleep_after_interrupt && irq) st <= prox_pkg::ST_HALT;
          else if (idle_go) st <= prox_pkg::ST_ACTIVE;
        end
        // Oscillator stopped; irq falling, from a flag clear or a mask write, wakes the loop
        prox_pkg::ST_HALT: if (!irq) st <= prox_pkg::ST_IDLE;
        default: st <= prox_pkg::ST_SLEEP;
      endcase
    end
  end

  // Pulse train within one sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat <= '0;
      samp_cnt <= 20'h0_0000;
      ph_cnt <= 10'h000;
      ph_high <= 1'b0;
      pulses_done <= 7'h00;
    end else if (go_sample) begin
      lat <= cfg;
      samp_cnt <= 20'h0_0000;
      ph_high <= 1'b1;
      ph_cnt <= prox_pkg::pulse_cycles(cfg.pulse_width) - 10'h001;
      pulses_done <= 7'h00;
    end else if (st == prox_pkg::ST_ACTIVE && cfg.power_on) begin
      samp_cnt <= samp_cnt + 20'h0_0001;
      if (ph_cnt != 10'h000) begin
        ph_cnt <= ph_cnt - 10'h001;
      end else if (ph_high) begin
        ph_high <= 1'b0;
        pulses_done <= pulses_done + 7'h01;
        ph_cnt <= width_cyc - 10'h001;
      end else if (!pulses_all) begin
        ph_high <= 1'b1;
        ph_cnt <= width_cyc - 10'h001;
      end
    end else begin
      ph_high <= 1'b0;
    end
  end
  // Averaging, wait and warm-up counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      avg_left <= 8'h00;
      wait_cnt <= 32'h0000_0000;
      warm_cnt <= 3'h0;
    end else if (!cfg.power_on || st == prox_pkg::ST_SLEEP) begin
      avg_left <= pow2_minus1(cfg.avg_log2);
      wait_cnt <= 32'h0000_0000;
      warm_cnt <= 3'h0;
    end else begin
      if (cyc_end) begin
        avg_left <= pow2_minus1(cfg.avg_log2);
        if (!result_ok) warm_cnt <= warm_cnt + 3'h1;
      end else if (samp_end) begin
        avg_left <= avg_left - 8'h01;
      end
      if (st == prox_pkg::ST_IDLE && !idle_go)
        wait_cnt <= wait_cnt + 32'h0000_0001;
      else
        wait_cnt <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Status, interrupt and read data
  // ----------------------------------------------------------------
  // Set wins over a clear by read in the same cycle
  wire [1:0] stat_set = {cyc_end && result_ok, samp_end};
  wire [1:0] next_stat = (rd_clr ? 2'b00 : stat) | stat_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat <= 2'b00;
      irq <= 1'b0;
    end else begin
      stat <= next_stat;
      irq <= |(next_stat & mask_q[1:0]);
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (araddr == prox_pkg::REG_CTRL) rd_word = ctrl_q;
    else if (araddr == prox_pkg::REG_PULSE) rd_word = pulse_q;
    else if (araddr == prox_pkg::REG_TIMING) rd_word = timing_q;
    else if (araddr == prox_pkg::REG_STATUS) rd_word = {30'h0, stat};
    else if (araddr == prox_pkg::REG_MASK) rd_word = mask_q;
    else if (araddr == prox_pkg::REG_STATE) begin
      rd_word[1:0] = st;
      rd_word[prox_pkg::STATE_PULSES_LSB +: 7] = pulses_done;
      rd_word[prox_pkg::STATE_AVG_LSB +: 8] = avg_left;
    end else rd_hit = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= prox_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_hit ? prox_pkg::RESP_OKAY : prox_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  assign emitter_en = ph_high;
  assign emitter_drive = lat.drive;
  assign active = st == prox_pkg::ST_ACTIVE;
  assign sleeping = st == prox_pkg::ST_SLEEP || st == prox_pkg::ST_HALT;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [9:0] hi_len;
  logic [6:0] rises;
  logic emit_d;
  logic [31:0] idle_len;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_len <= 10'h000;
      rises <= 7'h00;
      emit_d <= 1'b0;
      idle_len <= 32'h0000_0000;
    end else begin
      hi_len <= emitter_en ? hi_len + 10'h001 : 10'h000;
      emit_d <= emitter_en;
      if (samp_end || !active) rises <= 7'h00;
      else if (emitter_en && !emit_d) rises <= rises + 7'h01;
      idle_len <= st == prox_pkg::ST_IDLE ? idle_len + 32'h0000_0001 :
                  32'h0000_0000;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_emit_active: assert property (emitter_en |-> active)
    else $error("emitter on outside active state");
  chk_pulse_width: assert property ($fell(emitter_en) &&
    $past(cfg.power_on) |-> hi_len == width_cyc)
    else $error("pulse high time wrong");
  chk_pulse_count: assert property (samp_end |->
    rises + 7'(emitter_en && !emit_d) == pulse_total)
    else $error("pulse count per sample wrong");
  chk_sample_len: assert property (samp_end |->
    samp_cnt + 20'h0_0001 >= period_cyc && !emitter_en)
    else $error("sample ended early");
  chk_wait_len: assert property ($rose(active) &&
    $past(st) == prox_pkg::ST_IDLE && $past(lat.wait_en) |->
    $past(idle_len) + 32'h0000_0001 == $past(wait_target))
    else $error("inter-sample wait length wrong");
  chk_sleep_off: assert property (!cfg.power_on |=>
    sleeping && !emitter_en) else $error("not asleep with power off");
  chk_avg_repeat: assert property (samp_end && avg_left != 8'h00
    |=> active ##0 samp_cnt == 20'h0_0000)
    else $error("averaging repeat missing");
  chk_halt_sai: assert property (st == prox_pkg::ST_IDLE && cfg.sleep_after_interrupt && irq &&
    cfg.power_on |=> st == prox_pkg::ST_HALT)
    else $error("no halt after interrupt");
  chk_loop_repeat: assert property (cyc_end && cfg.power_on &&
    !lat.wait_en && !cfg.sleep_after_interrupt |=> ##1 active)
    else $error("loop did not repeat");

  cov_avg: cover property (samp_end && avg_left != 8'h00);
  cov_halt: cover property (st == prox_pkg::ST_HALT ##[1:20] !sleeping);
  cov_stretch: cover property (samp_end && samp_cnt + 20'h0_0001 > period_cyc);
  cov_irq: cover property ($rose(irq));

endmodule : proximity_cycle_sequencer

//--- tb/axi_host.sv
`timescale 1ns/1ns

module axi_host (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // Called just after a rising edge; returns one edge after the answer
  task automatic write(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    // Released payload must not look like a stale valid word
    wdata <= ~d;
    awaddr <= ~a;
    @(posedge aclk);
  endtask : write

  task automatic read(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    araddr <= ~a;
    @(posedge aclk);
  endtask : read
endmodule : axi_host

//--- tb/tb.sv
`timescale 1ns/1ns

module tb;
  // ------------------------------------------------------------
  // Wiring
  // ------------------------------------------------------------
  // Short wait unit keeps the long-wait case inside the run budget
  localparam int unsigned WU = 8;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, emitter_drive;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic emitter_en, active, sleeping, irq;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [63:0] sq[$];
  int iq[$];
  int mismatches = 0;
  int total_checks = 0;
  logic [1:0] drv_exp = 2'b00;
  int alen, hi, np, idl;
  logic act_d, pe;
  int wus[8] = '{1, 2, 4, 8, 12, 16, 24, 32};
  logic [7:0] ra[4] = '{prox_pkg::REG_CTRL, prox_pkg::REG_PULSE,
                        prox_pkg::REG_TIMING, prox_pkg::REG_MASK};
  logic [31:0] rv[4] = '{prox_pkg::CTRL_RESET, prox_pkg::PULSE_RESET,
                         prox_pkg::TIMING_RESET, prox_pkg::MASK_RESET};
  logic [31:0] wm[4] = '{prox_pkg::CTRL_WMASK, prox_pkg::PULSE_WMASK,
                         prox_pkg::TIMING_WMASK, prox_pkg::MASK_WMASK};

  initial forever #25 aclk = ~aclk;

  proximity_cycle_sequencer #(.WAIT_UNIT_CYC(WU)) i_proximity_cycle_sequencer (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .emitter_en, .emitter_drive, .active,
    .sleeping, .irq
  );

  axi_host host (
    .aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rvalid, .rready
  );

  // ------------------------------------------------------------
  // Checking
  // ------------------------------------------------------------
  task automatic check(input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : check

  task automatic give_verdict();
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Counters restart in sleep so an aborted sample is never scored
  always @(posedge aclk) begin
    if ((bvalid && bready) === 1'b1) check(64'(bq.pop_front()), 64'(bresp));
    if ((rvalid && rready) === 1'b1) check(64'(rq.pop_front()),
                                           64'({rresp, rdata}));
    if (emitter_en !== 1'b0) check(64'(1), 64'(active));
    if (active === 1'b1) check(64'(drv_exp), 64'(emitter_drive));
    if (aresetn !== 1'b1 || sleeping !== 1'b0) begin
      alen = 0;
      hi = 0;
      np = 0;
      idl = 0;
    end else begin
      alen += int'(active);
      hi += int'(emitter_en);
      np += int'(emitter_en && !pe);
      idl += int'(!active);
      if (act_d && !active) begin
        if (sq.size() > 0) check(sq.pop_front(), {16'(np), 24'(hi), 24'(alen)});
        alen = 0;
        hi = 0;
        np = 0;
      end
      if (!act_d && active) begin
        if (iq.size() > 0 && idl > 0) check(64'(iq.pop_front()), 64'(idl));
        idl = 0;
      end
    end
    act_d = active;
    pe = emitter_en;
  end

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    bq.push_back(r);
    host.write(a, d, s);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    rq.push_back({r, d});
    host.read(a);
  endtask : rd

  task automatic wait_fall();
    int n;
    n = 0;
    while (active !== 1'b1 && n < 30000) begin
      @(posedge aclk);
      n++;
    end
    while (active === 1'b1 && n < 30000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 30000) mismatches++;
  endtask : wait_fall

  // Loads a loop setup, notes each group and gap, runs until all are seen
  task automatic run(input logic [5:0] pc, input logic [2:0] pw,
                     input logic [7:0] per, input logic [7:0] wt,
                     input logic [2:0] av, input logic [3:0] ctl,
                     input int grp);
    int w, len, n;
    w = wus[pw] * prox_pkg::CYC_PER_US;
    n = (pc + 1) << av;
    len = (per + 1) * prox_pkg::SAMPLE_UNIT_CYC;
    if ((2 * pc + 1) * w >= len) len = (2 * pc + 1) * w + 1;
    drv_exp = 2'($urandom);
    wr(prox_pkg::REG_PULSE, {18'h0, drv_exp, 1'b0, pw, 2'b0, pc}, 4'hF, 2'b00);
    wr(prox_pkg::REG_TIMING, {13'h0, av, wt, per}, 4'hF, 2'b00);
    for (int g = 0; g < grp; g++) begin
      sq.push_back({16'(n), 24'(n * w), 24'(len << av)});
      if (g > 0) iq.push_back(!ctl[1] ? 1 : (wt + 1) * WU * (ctl[2] ? 12 : 1));
    end
    wr(prox_pkg::REG_CTRL, {28'h0, ctl | 4'h1}, 4'hF, 2'b00);
    n = 0;
    while ((sq.size() > 0 || iq.size() > 0) && n < 40000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 40000) mismatches++;
    wr(prox_pkg::REG_CTRL, {28'h0, ctl & 4'hE}, 4'hF, 2'b00);
  endtask : run

  initial begin
    void'($urandom(61));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      rd(ra[i], rv[i], 2'b00);
      wr(ra[i], 32'hFFFF_FFFE, 4'hF, 2'b00);
      rd(ra[i], 32'hFFFF_FFFE & wm[i], 2'b00);
      wr(ra[i], rv[i], 4'hF, 2'b00);
    end
    rd(prox_pkg::REG_STATUS, 32'h0000_0000, 2'b00);
    wr(prox_pkg::REG_PULSE, 32'hFFFF_FFFF, 4'h1, 2'b00);
    rd(prox_pkg::REG_PULSE, 32'h0000_053F, 2'b00);
    wr(8'h18, 32'hFFFF_FFFF, 4'hF, prox_pkg::RESP_SLVERR);
    rd(8'h18, 32'h0000_0000, prox_pkg::RESP_SLVERR);
    for (int c = 0; c < 8; c++) run(6'd1, 3'(c), 8'd0, 8'd0, 3'd0, 4'h0, 1);
    run(6'd63, 3'd0, 8'd0, 8'd0, 3'd0, 4'h0, 1);
    run(6'd0, 3'($urandom), 8'($urandom % 4), 8'd0, 3'd0, 4'h0, 2);
    run(6'($urandom % 4), 3'd1, 8'd1, 8'd3, 3'd0, 4'h2, 2);
    run(6'd2, 3'd0, 8'd0, 8'd1, 3'd0, 4'h6, 2);
    run(6'd0, 3'd0, 8'd0, 8'd0, 3'd1, 4'h0, 2);
    run(6'd0, 3'd0, 8'd0, 8'd0, 3'd3, 4'h0, 1);
    // Flags left by the loop runs must not leak into the interrupt cases
    rd(prox_pkg::REG_STATUS, 32'h0000_0003, 2'b00);
    // Warm-up of a four-deep moving average, events on the interrupt
    wr(prox_pkg::REG_MASK, 32'h0000_0003, 4'hF, 2'b00);
    wr(prox_pkg::REG_TIMING, 32'h0020_1400, 4'hF, 2'b00);
    wr(prox_pkg::REG_CTRL, 32'h0000_0003, 4'hF, 2'b00);
    for (int g = 1; g <= 5; g++) begin
      wait_fall();
      repeat (4) @(posedge aclk);
      check(64'(1), 64'(irq));
      rd(prox_pkg::REG_STATUS, {30'h0, g >= 4, 1'b1}, 2'b00);
      repeat (3) @(posedge aclk);
      check(64'(0), 64'(irq));
    end
    wr(prox_pkg::REG_CTRL, 32'h0000_0000, 4'hF, 2'b00);
    // Halt after an interrupt, restart only once the host clears status
    wr(prox_pkg::REG_TIMING, 32'h0000_1400, 4'hF, 2'b00);
    wr(prox_pkg::REG_MASK, 32'h0000_0001, 4'hF, 2'b00);
    wr(prox_pkg::REG_CTRL, 32'h0000_000B, 4'hF, 2'b00);
    wait_fall();
    repeat (200) @(posedge aclk);
    check(64'(2'b10), 64'({sleeping, active}));
    rd(prox_pkg::REG_STATUS, 32'h0000_0003, 2'b00);
    repeat (4) @(posedge aclk);
    check(64'(0), 64'(sleeping));
    wr(prox_pkg::REG_CTRL, 32'h0000_0000, 4'hF, 2'b00);
    give_verdict();
  end

  initial begin
    repeat (95000) @(posedge aclk);
    mismatches++;
    give_verdict();
  end
endmodule : tb
